// file: sepa_pkg.sv
// Purpose: shared constants and types of the serial eeprom command and protection block
// Assumes: 25 MHz system clock, serial link sampled as plain inputs
// Notes: nonvolatile status bits live outside the synchronous reset
//
// Contract
// [R1] busy_flag reads 1 through the internal write cycle, 0 afterwards; never host-written.
// [R2] set_write_latch_cmd sets write_enable_latch, clear_write_latch_cmd clears it.
// [R3] status word: bit7 pin enable, 6..4 zero, 3..2 block protect, 1 latch, 0 busy.
// [R4] block-protect bits change only by write_status_cmd and survive power loss.
// [R5] protect codes 00 none, 01 0C00-0FFF, 10 0800-0FFF, 11 whole array.
// [R6] pin low with pin enable set refuses status writes and protected-block writes.
// [R7] latch clear refuses all writes; protected blocks never accept writes.
// [R8] after power-up the write latch is clear.
// [R9] latch sets only when chip select rises right after the set command byte.
// [R10] host sends set_write_latch_cmd in an earlier session before every write.
// [R11] write session is opcode, 16-bit address, data; only low 12 bits used.
// [R12] programming starts only at the chip select rise ending a valid write session.
// [R13] during an internal write only read_status_cmd is accepted.
// [R14] up to 32 data bytes, column increments and wraps inside the page.
// [R15] the end of an internal write cycle clears the write latch.
// [R16] write_status_cmd updates only status bits 2, 3 and 7.
// [R17] protect pin falling during a status write session aborts it; later no effect. Here it aborts only with pin enable set.
// [R18] read streams array bytes from the address, wrapping top to bottom, until deselect.
// [R19] read_status_cmd streams the full status word, also during a write cycle.
// [R20] host polls busy_flag and trusts the status read after it shows 0.
// [R21] host toggles pause_input only while serial clock is low, chip select low.
// [R22] while paused the output floats and serial input is ignored, state kept.
// [R23] exactly six opcodes are recognised; all other bytes are ignored.
// [R24] input sampled on rising clock edges, output changed on falling edges.
// [R25] chip select high floats the output and idles, a running write continues.
// [R26] all fields travel most significant bit first.
package sepa_pkg;

  localparam int ADDR_W = 12;
  localparam int COL_W = 5;
  localparam int PAGE_W = ADDR_W - COL_W;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 4096;
  localparam int TIMER_W = 17;

  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_PIN_EN = 7;

  localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 12'h0c00;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 12'h0800;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] ADDR_BIT_LAST = 4'hf;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WRITE_CYCLE_NS = 5000000;
  // longest time: rounded down
  localparam int unsigned WRITE_CYCLE_CLKS = WRITE_CYCLE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SEPA_IGNORE = 3'h0,
    SEPA_OPCODE = 3'h1,
    SEPA_ADDR = 3'h3,
    SEPA_WDATA = 3'h2,
    SEPA_RDATA = 3'h6,
    SEPA_RSTAT = 3'h7,
    SEPA_WSTAT = 3'h5,
    SEPA_WEL_END = 3'h4
  } sepa_state_t;

endpackage : sepa_pkg

// file: sepa_link_if.sv
// Purpose: carries synchronised serial pin levels and edges to the core
// Assumes: all members live in the system clock domain
// Notes: edges are one-cycle pulses
`timescale 1ns/1ps
interface sepa_link_if;
  logic cs_n;
  logic si;
  logic hold_n;
  logic wp_n;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic wp_fall;

  modport src (output cs_n, si, hold_n, wp_n, sck_rise, sck_fall, cs_rise, cs_fall, wp_fall);
  modport dst (input cs_n, si, hold_n, wp_n, sck_rise, sck_fall, cs_rise, cs_fall, wp_fall);
endinterface : sepa_link_if

// file: sepa_pin_sync.sv
// Purpose: two-flop synchronisers and edge finders for the serial pins
// Assumes: serial clock is far slower than clk
// Notes: edges are found on the second and third stages only
`timescale 1ns/1ps
module sepa_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic hold_n_pin,
  input wire logic wp_n_pin,
  sepa_link_if.src lnk
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
  } sepa_sync_t;

  sepa_sync_t q_ff;
  sepa_sync_t nxt_q;

  // order: cs_n, sck, si, hold_n, wp_n; idle levels are high except sck and si
  localparam logic [4:0] SYNC_IDLE = 5'h13;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = {cs_n_pin, sck_pin, si_pin, hold_n_pin, wp_n_pin};
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '{s1: SYNC_IDLE, s2: SYNC_IDLE, s3: SYNC_IDLE};
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end

  assign lnk.cs_n = q_ff.s2[4];
  assign lnk.si = q_ff.s2[2];
  assign lnk.hold_n = q_ff.s2[1];
  assign lnk.wp_n = q_ff.s2[0];
  assign lnk.sck_rise = q_ff.s2[3] & ~q_ff.s3[3];
  assign lnk.sck_fall = ~q_ff.s2[3] & q_ff.s3[3];
  assign lnk.cs_rise = q_ff.s2[4] & ~q_ff.s3[4];
  assign lnk.cs_fall = ~q_ff.s2[4] & q_ff.s3[4];
  assign lnk.wp_fall = ~q_ff.s2[0] & q_ff.s3[0];

endmodule : sepa_pin_sync

// file: sepa_eeprom_core.sv
// Purpose: command decoder, status word, write protection and array of a serial eeprom
// Assumes: host serial clock at most one eighth of clk; pins arrive asynchronously
// Notes: block-protect and pin-enable bits are kept across rst as nonvolatile state
`timescale 1ns/1ps
module sepa_eeprom_core #(
  parameter int unsigned WRITE_CYCLES = sepa_pkg::WRITE_CYCLE_CLKS,
  parameter logic [2:0] NV_INIT = 3'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe_n,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    sepa_pkg::sepa_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [2:0] tcnt;
    logic [sepa_pkg::ADDR_W-1:0] rd_addr;
    logic [sepa_pkg::PAGE_W-1:0] page;
    logic [sepa_pkg::COL_W-1:0] col;
    logic [sepa_pkg::PAGE_BYTES-1:0] mask;
    logic got_byte;
    logic [7:0] stat_new;
    logic wp_abort;
    logic busy;
    logic write_enable_latch;
    logic [1:0] bp;
    logic pin_en;
    logic prog_arr;
    logic [sepa_pkg::COL_W:0] prog_cnt;
    logic [sepa_pkg::TIMER_W-1:0] timer;
    logic so;
    logic oe_n;
  } sepa_core_t;

  localparam logic [sepa_pkg::TIMER_W-1:0] TIMER_LOAD =
    sepa_pkg::TIMER_W'(WRITE_CYCLES - 1);

  sepa_core_t q_ff = '{st: sepa_pkg::SEPA_IGNORE, bp: NV_INIT[1:0], pin_en: NV_INIT[2],
                       oe_n: 1'b1, default: '0};
  sepa_core_t nxt_q;

  logic [7:0] arr_mem [sepa_pkg::MEM_BYTES];
  logic [7:0] page_buf [sepa_pkg::PAGE_BYTES];

  logic mem_we;
  logic [sepa_pkg::ADDR_W-1:0] mem_waddr;
  logic buf_we;
  logic [7:0] rx_byte;
  logic [7:0] stat_word;
  logic [7:0] tx_byte;
  logic hw_prot;

  sepa_link_if lnk ();

  sepa_pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cs_n_pin(cs_n),
    .sck_pin(sck),
    .si_pin(si),
    .hold_n_pin(hold_n),
    .wp_n_pin(wp_n),
    .lnk(lnk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic prot_f(input logic [1:0] bp, input logic [sepa_pkg::ADDR_W-1:0] a);
    unique case (bp)
      2'h0: prot_f = 1'b0;
      2'h1: prot_f = (a >= sepa_pkg::PROT_QUARTER_BASE); // see [R5]
      2'h2: prot_f = (a >= sepa_pkg::PROT_HALF_BASE); // see [R5]
      2'h3: prot_f = 1'b1; // see [R5]
    endcase
  endfunction : prot_f

  always_comb begin
    stat_word = '0; // see [R3]
    stat_word[sepa_pkg::ST_PIN_EN] = q_ff.pin_en;
    stat_word[sepa_pkg::ST_BP_HI] = q_ff.bp[1];
    stat_word[sepa_pkg::ST_BP_LO] = q_ff.bp[0];
    stat_word[sepa_pkg::ST_WEL] = q_ff.write_enable_latch;
    stat_word[sepa_pkg::ST_BUSY] = q_ff.busy;
  end

  // msb first on both directions
  assign rx_byte = {q_ff.sh[6:0], lnk.si}; // see [R26]
  assign tx_byte = (q_ff.st == sepa_pkg::SEPA_RSTAT) ? stat_word : arr_mem[q_ff.rd_addr];
  assign hw_prot = q_ff.pin_en & ~lnk.wp_n; // see [R6]

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_q = q_ff;
    buf_we = 1'b0;
    mem_we = 1'b0;
    mem_waddr = {q_ff.page, q_ff.prog_cnt[sepa_pkg::COL_W-1:0]};

    // self-timed cycle runs whatever the link does
    if (q_ff.busy) begin // see [R25]
      if (q_ff.prog_arr && !q_ff.prog_cnt[sepa_pkg::COL_W]) begin
        mem_we = q_ff.mask[q_ff.prog_cnt[sepa_pkg::COL_W-1:0]];
        nxt_q.prog_cnt = q_ff.prog_cnt + 1'b1;
      end
      if (q_ff.timer == '0) begin
        nxt_q.busy = 1'b0; // see [R1]
        nxt_q.write_enable_latch = 1'b0; // see [R15]
        nxt_q.prog_arr = 1'b0;
      end else begin
        nxt_q.timer = q_ff.timer - 1'b1;
      end
    end

    if (lnk.cs_fall) begin
      nxt_q.st = sepa_pkg::SEPA_OPCODE;
      nxt_q.cnt = '0;
      nxt_q.wp_abort = 1'b0;
      nxt_q.got_byte = 1'b0;
    end else if (lnk.cs_rise) begin
      nxt_q.st = sepa_pkg::SEPA_IGNORE; // see [R25]
      unique case (q_ff.st)
        sepa_pkg::SEPA_WEL_END: nxt_q.write_enable_latch = 1'b1; // see [R9] [R2]
        sepa_pkg::SEPA_WDATA: begin
          // a partial trailing byte spoils the whole session
          if (q_ff.got_byte && q_ff.cnt == '0 && q_ff.write_enable_latch &&
              !prot_f(q_ff.bp, {q_ff.page, {sepa_pkg::COL_W{1'b0}}})) begin // see [R7] [R12]
            nxt_q.busy = 1'b1; // see [R1]
            nxt_q.prog_arr = 1'b1;
            nxt_q.prog_cnt = '0;
            nxt_q.timer = TIMER_LOAD;
          end
        end
        sepa_pkg::SEPA_WSTAT: begin
          if (q_ff.got_byte && q_ff.cnt == '0 && q_ff.write_enable_latch && !hw_prot &&
              !q_ff.wp_abort) begin // see [R6] [R7] [R12] [R17]
            nxt_q.bp = {q_ff.stat_new[sepa_pkg::ST_BP_HI],
                        q_ff.stat_new[sepa_pkg::ST_BP_LO]}; // see [R4] [R16]
            nxt_q.pin_en = q_ff.stat_new[sepa_pkg::ST_PIN_EN]; // see [R16]
            nxt_q.busy = 1'b1;
            nxt_q.prog_arr = 1'b0;
            nxt_q.timer = TIMER_LOAD;
          end
        end
        default: begin
        end
      endcase
    end else if (!lnk.cs_n && lnk.hold_n) begin // see [R22]
      if (lnk.wp_fall && q_ff.pin_en && q_ff.st == sepa_pkg::SEPA_WSTAT) begin
        nxt_q.wp_abort = 1'b1; // see [R17]
      end
      if (lnk.sck_rise) begin // see [R24]
        nxt_q.sh = rx_byte;
        nxt_q.cnt = q_ff.cnt + 1'b1;
        unique case (q_ff.st)
          sepa_pkg::SEPA_OPCODE: begin
            if (q_ff.cnt[2:0] == sepa_pkg::BIT_LAST) begin
              nxt_q.cnt = '0;
              nxt_q.tcnt = '0;
              nxt_q.st = sepa_pkg::SEPA_IGNORE; // see [R23]
              if (q_ff.busy && rx_byte != sepa_pkg::OP_RD_STAT) begin
                nxt_q.st = sepa_pkg::SEPA_IGNORE; // see [R13]
              end else begin
                unique case (rx_byte)
                  sepa_pkg::OP_SET_WEL: nxt_q.st = sepa_pkg::SEPA_WEL_END; // see [R9]
                  sepa_pkg::OP_CLR_WEL: nxt_q.write_enable_latch = 1'b0; // see [R2]
                  sepa_pkg::OP_RD_STAT: nxt_q.st = sepa_pkg::SEPA_RSTAT; // see [R19]
                  sepa_pkg::OP_WR_STAT: nxt_q.st = sepa_pkg::SEPA_WSTAT;
                  sepa_pkg::OP_READ: begin
                    nxt_q.st = sepa_pkg::SEPA_ADDR;
                    nxt_q.prog_arr = 1'b0;
                  end
                  sepa_pkg::OP_WRITE: begin
                    nxt_q.st = sepa_pkg::SEPA_ADDR;
                    nxt_q.prog_arr = 1'b1;
                    nxt_q.mask = '0;
                  end
                  default: nxt_q.st = sepa_pkg::SEPA_IGNORE; // see [R23]
                endcase
              end
            end
          end
          sepa_pkg::SEPA_ADDR: begin
            // prog_arr marks a write session until the address is complete
            nxt_q.rd_addr = {q_ff.rd_addr[sepa_pkg::ADDR_W-2:0], lnk.si}; // see [R11]
            if (q_ff.cnt == sepa_pkg::ADDR_BIT_LAST) begin
              nxt_q.cnt = '0;
              nxt_q.prog_arr = 1'b0;
              nxt_q.page = q_ff.rd_addr[sepa_pkg::ADDR_W-2:sepa_pkg::COL_W-1];
              nxt_q.col = {q_ff.rd_addr[sepa_pkg::COL_W-2:0], lnk.si};
              nxt_q.st = q_ff.prog_arr ? sepa_pkg::SEPA_WDATA : sepa_pkg::SEPA_RDATA; // see [R18]
            end
          end
          sepa_pkg::SEPA_WDATA: begin
            if (q_ff.cnt[2:0] == sepa_pkg::BIT_LAST) begin
              nxt_q.cnt = '0;
              buf_we = 1'b1;
              nxt_q.mask[q_ff.col] = 1'b1;
              nxt_q.col = q_ff.col + 1'b1; // see [R14]
              nxt_q.got_byte = 1'b1;
            end
          end
          sepa_pkg::SEPA_WSTAT: begin
            if (q_ff.cnt[2:0] == sepa_pkg::BIT_LAST) begin
              nxt_q.cnt = '0;
              nxt_q.stat_new = rx_byte;
              nxt_q.got_byte = 1'b1;
            end
          end
          // extra clocks after the set command cancel it
          sepa_pkg::SEPA_WEL_END: nxt_q.st = sepa_pkg::SEPA_IGNORE; // see [R9]
          sepa_pkg::SEPA_RDATA, sepa_pkg::SEPA_RSTAT, sepa_pkg::SEPA_IGNORE: begin
          end
        endcase
      end
      if (lnk.sck_fall &&
          (q_ff.st == sepa_pkg::SEPA_RDATA || q_ff.st == sepa_pkg::SEPA_RSTAT)) begin // see [R24]
        nxt_q.so = tx_byte[sepa_pkg::BIT_LAST - q_ff.tcnt]; // see [R26]
        nxt_q.tcnt = q_ff.tcnt + 1'b1;
        if (q_ff.tcnt == sepa_pkg::BIT_LAST && q_ff.st == sepa_pkg::SEPA_RDATA) begin
          nxt_q.rd_addr = q_ff.rd_addr + 1'b1; // see [R18]
        end
      end
    end

    // output floats when deselected, paused or not streaming
    nxt_q.oe_n = lnk.cs_n || !lnk.hold_n ||
                 !(nxt_q.st == sepa_pkg::SEPA_RDATA ||
                   nxt_q.st == sepa_pkg::SEPA_RSTAT); // see [R22] [R25]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (rst) begin
      // nonvolatile bits ride through reset; latch starts clear
      q_ff <= '{st: sepa_pkg::SEPA_IGNORE, bp: q_ff.bp, pin_en: q_ff.pin_en,
                oe_n: 1'b1, default: '0}; // see [R4] [R8]
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && buf_we) begin
      page_buf[q_ff.col] <= rx_byte; // see [R14]
    end
  end

  always_ff @(posedge clk) begin
    if (ce && mem_we) begin
      arr_mem[mem_waddr] <= page_buf[q_ff.prog_cnt[sepa_pkg::COL_W-1:0]];
    end
  end

  assign so = q_ff.so;
  assign so_oe_n = q_ff.oe_n;
  assign busy = q_ff.busy;

endmodule : sepa_eeprom_core

// file: sepa_eeprom_core_props.sv
// Purpose: port checks of the serial eeprom core
// Assumes: ce high, pins reach the core 2..3 clk late
// Notes: one or two clk of margin absorb synchroniser phase
`timescale 1ns/1ps
module sepa_eeprom_core_props #(
  parameter int unsigned WRITE_CYCLES = 400
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic busy
);
  logic [16:0] busy_cnt_ff;
  always_ff @(posedge clk) begin
    if (rst || !busy) begin
      busy_cnt_ff <= 17'h0_0000;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 17'h0_0001;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_reset_idle: assert property ($fell(rst) |-> so_oe_n && !busy)
    else $error("outputs not idle after reset");
  a_float_deselect: assert property ((cs_n && ce) [*6] |-> so_oe_n)
    else $error("so driven while deselected");
  a_hold_float: assert property ((!hold_n && ce) [*6] |-> so_oe_n)
    else $error("so driven while paused");
  a_drive_needs_cs: assert property (!so_oe_n |-> !$past(cs_n, 5))
    else $error("so driven without a session");
  a_busy_after_cs: assert property ($rose(busy) |-> cs_n && $past(cs_n, 2))
    else $error("write cycle began inside a session");
  a_busy_min_hold: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped early");
  // lower bound and upper bound of the self-timed cycle
  a_busy_length: assert property ($fell(busy) |->
    busy_cnt_ff >= WRITE_CYCLES - 1 && busy_cnt_ff <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  a_so_on_fall: assert property ($changed(so) && !so_oe_n |-> !$past(sck, 2))
    else $error("so changed outside a falling edge");
  cover property ($rose(busy));
  cover property ($fell(so_oe_n));
  cover property (!hold_n && !cs_n);
endmodule : sepa_eeprom_core_props
bind sepa_eeprom_core sepa_eeprom_core_props #(.WRITE_CYCLES(WRITE_CYCLES))
  sepa_eeprom_core_props_inst (.clk(clk), .rst(rst), .ce(ce), .cs_n(cs_n),
  .sck(sck), .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n), .busy(busy));

// file: sepa_host_model.sv
// Purpose: serial host driving the eeprom pins in mode 0
// Assumes: sck half period of 4 clk, 320 ns per bit
// Notes: so is sampled late in the high phase, clear of the output change
`timescale 1ns/1ps
module sepa_host_model (
  input wire logic clk,
  input wire logic so,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic start();
    cs_n = 1'b0;
    tick(4);
  endtask : start
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      tick(4);
      sck = 1'b1;
      tick(4);
      rx[i] = so;
      sck = 1'b0;
    end
  endtask : xfer
  // si is flipped when released so a stale level is never trusted
  task automatic stop();
    tick(4);
    cs_n = 1'b1;
    si = ~si;
    tick(8);
  endtask : stop
  // let the last sck fall settle first, else it is seen together with the pause
  task automatic pause(input int n);
    tick(4);
    hold_n = 1'b0;
    tick(n);
    hold_n = 1'b1;
    tick(4);
  endtask : pause
endmodule : sepa_host_model

// file: sepa_eeprom_core_bench.sv
// Purpose: self-checking bench of the serial eeprom core
// Assumes: write cycle cut to 400 clk, nonvolatile bits start at 0
// Notes: the host sees z on so whenever the core floats it
`timescale 1ns/1ps
module sepa_eeprom_core_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cs_n, sck, si, hold_n, wp_n, so, so_oe_n, busy;
  wire so_bus = so_oe_n ? 1'bz : so;
  int fails = 0;
  int compares = 0;
  logic [7:0] got[$];
  always #20 clk = ~clk;
  sepa_eeprom_core #(.WRITE_CYCLES(400), .NV_INIT(3'h0)) sepa_eeprom_core_inst (
    .clk(clk), .rst(rst), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .busy(busy));
  sepa_host_model sepa_host_model_inst (.clk(clk), .so(so_bus), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic send(input logic [7:0] q[$]);
    logic [7:0] r;
    got.delete();
    sepa_host_model_inst.start();
    foreach (q[i]) begin
      sepa_host_model_inst.xfer(q[i], r);
      got.push_back(r);
    end
    sepa_host_model_inst.stop();
  endtask : send
  task automatic rd_stat(input logic [7:0] e);
    send('{sepa_pkg::OP_RD_STAT, 8'hff});
    cmp(got[1], e);
  endtask : rd_stat
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      send('{sepa_pkg::OP_RD_STAT, 8'hff});
      if (got[1][sepa_pkg::ST_BUSY] === 1'b0) break;
    end
    cmp({7'h0, busy}, 8'h00);
  endtask : wait_idle
  // upper address nibble is sent as ones, which the core must drop
  task automatic wr(input logic [7:0] op, input logic [11:0] a, input logic [7:0] d,
                    input logic eb);
    send('{sepa_pkg::OP_SET_WEL});
    if (op == sepa_pkg::OP_WRITE) begin
      send('{op, {4'hf, a[11:8]}, a[7:0], d});
    end else begin
      send('{op, d});
    end
    cmp({7'h0, busy}, {7'h0, eb});
    wait_idle();
  endtask : wr
  ////////////////////////////////////////////////////////////
  task automatic t_latch();
    rd_stat(8'h00);
    send('{sepa_pkg::OP_SET_WEL});
    rd_stat(8'h02);
    send('{sepa_pkg::OP_CLR_WEL});
    rd_stat(8'h00);
    // a frozen core must miss a whole session
    ce = 1'b0;
    send('{sepa_pkg::OP_SET_WEL});
    ce = 1'b1;
    rd_stat(8'h00);
    send('{sepa_pkg::OP_SET_WEL, 8'h00});
    rd_stat(8'h00);
    send('{8'ha5, 8'hff});
    cmp(got[1], 8'hzz);
    send('{sepa_pkg::OP_WRITE, 8'h00, 8'h40, 8'h77});
    cmp({7'h0, busy}, 8'h00);
  endtask : t_latch
  task automatic t_page();
    send('{sepa_pkg::OP_SET_WEL});
    send('{sepa_pkg::OP_WRITE, 8'hf0, 8'h1f, 8'ha1, 8'hb2});
    cmp({7'h0, busy}, 8'h01);
    send('{sepa_pkg::OP_SET_WEL});
    rd_stat(8'h03);
    wait_idle();
    rd_stat(8'h00);
    wr(sepa_pkg::OP_WRITE, 12'hfff, 8'hc3, 1'b1);
  endtask : t_page
  task automatic t_read();
    logic [7:0] r;
    sepa_host_model_inst.start();
    sepa_host_model_inst.xfer(sepa_pkg::OP_READ, r);
    sepa_host_model_inst.xfer(8'hff, r);
    sepa_host_model_inst.xfer(8'hff, r);
    sepa_host_model_inst.xfer(8'h00, r);
    cmp(r, 8'hc3);
    sepa_host_model_inst.pause(20);
    sepa_host_model_inst.xfer(8'h00, r);
    cmp(r, 8'hb2);
    sepa_host_model_inst.stop();
    send('{sepa_pkg::OP_READ, 8'h70, 8'h1f, 8'h00});
    cmp(got[3], 8'ha1);
  endtask : t_read
  task automatic t_protect();
    logic [11:0] b;
    wr(sepa_pkg::OP_WR_STAT, 12'h000, 8'hff, 1'b1);
    rd_stat(8'h8c);
    rst = 1'b1;
    sepa_host_model_inst.tick(4);
    rst = 1'b0;
    sepa_host_model_inst.tick(4);
    rd_stat(8'h8c);
    for (int k = 1; k < 4; k++) begin
      b = (k == 1) ? 12'hc00 : (k == 2) ? 12'h800 : 12'h000;
      wr(sepa_pkg::OP_WR_STAT, 12'h000, {6'h20, k[1:0]} << 2, 1'b1);
      wr(sepa_pkg::OP_WRITE, b, 8'h5a, 1'b0);
      if (k < 3) wr(sepa_pkg::OP_WRITE, b - 12'h001, 8'h5a, 1'b1);
    end
    wr(sepa_pkg::OP_WR_STAT, 12'h000, 8'h84, 1'b1);
    sepa_host_model_inst.wp_n = 1'b0;
    wr(sepa_pkg::OP_WR_STAT, 12'h000, 8'h00, 1'b0);
    wr(sepa_pkg::OP_WRITE, 12'hc00, 8'h5a, 1'b0);
    wr(sepa_pkg::OP_WRITE, 12'h000, 8'h5a, 1'b1);
    sepa_host_model_inst.wp_n = 1'b1;
    send('{sepa_pkg::OP_SET_WEL});
    sepa_host_model_inst.start();
    sepa_host_model_inst.xfer(sepa_pkg::OP_WR_STAT, b);
    sepa_host_model_inst.xfer(8'h00, b);
    sepa_host_model_inst.wp_n = 1'b0;
    sepa_host_model_inst.tick(8);
    sepa_host_model_inst.wp_n = 1'b1;
    sepa_host_model_inst.stop();
    cmp({7'h0, busy}, 8'h00);
    rd_stat(8'h86);
    wr(sepa_pkg::OP_WR_STAT, 12'h000, 8'h00, 1'b1);
    rd_stat(8'h00);
  endtask : t_protect
  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    sepa_host_model_inst.tick(4);
    t_latch();
    t_page();
    t_read();
    t_protect();
    end_of_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule : sepa_eeprom_core_bench
